// ==== design/rcbo_map.svh ====
// Overview of operation
// - Software reset sets the software-reset cause flag; it stays until software or a power-on reset clears it.
// - A reset from the external pin sets the pin-reset cause flag, bit 6.
// - Program counter beyond flash requests chip reset and sets fault flag, bit 5.
// - In debug with debug option 0, fault only sets the flag, no reset.
// - Bit 7 switches the detector; its output is ignored for three slow clocks.
// - Two-bit level field selects trip level: 11/10/01/00 are 2.2/2.7/3.7/4.4 V.
// - Threshold crossing either way sets event flag bit 3; interrupt needs both enables.
// - Bit 2 enables reset of the chip when supply drops below threshold.
// - A brown-out reset of the chip sets the brown-out reset flag, bit 1.
// - Read-only bit 0 reads 1 only while enabled and supply below threshold.
// - Every reset reloads enable, level and reset enable from option byte two.
// - Event flag reset value follows option byte and supply level during reset.
// - Writes to brown-out control take effect only after the timed-access unlock.
`ifndef RCBO_MAP_SVH
`define RCBO_MAP_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define RCBO_IDX_AUX        10'h0a2
`define RCBO_IDX_BOD        10'h0a3
`define RCBO_IDX_TA         10'h0c7
`define RCBO_IDX_NONE       10'h3ff

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RCBO_AUX_SW         7
`define RCBO_AUX_PIN        6
`define RCBO_AUX_FAULT      5
`define RCBO_BOD_ON         7
`define RCBO_BOD_LVL_HI     5
`define RCBO_BOD_LVL_LO     4
`define RCBO_BOD_EVT        3
`define RCBO_BOD_RSTON      2
`define RCBO_BOD_RSTF       1
`define RCBO_BOD_STATE      0

// ----------------------------------------------------------------
// Timed access and timing
// ----------------------------------------------------------------
`define RCBO_TA_KEY1        8'haa
`define RCBO_TA_KEY2        8'h55
`define RCBO_TA_WINDOW      3'h4
`define RCBO_BLANK_TICKS    2'h3

// ----------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------
`define RCBO_RESP_OKAY      2'h0
`define RCBO_RESP_SLVERR    2'h2

`endif

// ==== design/rcbo_pkg.sv ====
package rcbo_pkg;
   typedef enum logic [1:0] {TA_LOCKED, TA_KEY1, TA_OPEN} rcbo_ta_t;
   typedef logic [9:0] rcbo_idx_t;
endpackage

// ==== design/rcbo_bod_if.sv ====
`timescale 1ns/1ns
interface rcbo_bod_if;
   logic detectOn;
   logic belowSync;
   logic level;
   logic crossEvt;
   modport sense (input detectOn, output belowSync, output level, output crossEvt);
   modport ctrl  (output detectOn, input belowSync, input level, input crossEvt);
endinterface

// ==== design/rcbo_bod_sense.sv ====
`timescale 1ns/1ns
`include "rcbo_map.svh"
module rcbo_bod_sense
   import rcbo_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic reset,
   input  wire logic clkEn,
   input  wire logic cmpRaw,
   input  wire logic lircRaw,
   rcbo_bod_if.sense bod
);
   logic       cmpMeta_ff;
   logic       cmpSync_ff;
   logic       cmpPrev_ff;
   logic       lircMeta_ff;
   logic       lircSync_ff;
   logic       lircPrev_ff;
   logic [1:0] blankCnt_ff;
   logic       settled_ff;
   logic       level_ff;
   logic       evt_ff;
   logic       settledNow;

   // ----------------------------------------------------------------
   // Synchronisers, not reset so the level is seen during reset
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (clkEn) begin
         cmpMeta_ff  <= cmpRaw;
         cmpSync_ff  <= cmpMeta_ff;
         cmpPrev_ff  <= cmpSync_ff;
         lircMeta_ff <= lircRaw;
         lircSync_ff <= lircMeta_ff;
         lircPrev_ff <= lircSync_ff;
      end
   end

   // ----------------------------------------------------------------
   // Blanking after enable
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         blankCnt_ff <= 2'h0;
      end else if (clkEn) begin
         if (!bod.detectOn) begin
            blankCnt_ff <= 2'h0;
         end else if (lircSync_ff && !lircPrev_ff && blankCnt_ff != `RCBO_BLANK_TICKS) begin
            blankCnt_ff <= blankCnt_ff + 2'h1;
         end
      end
   end

   assign settledNow = bod.detectOn && (blankCnt_ff == `RCBO_BLANK_TICKS);

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         settled_ff <= 1'b0;
         level_ff   <= 1'b0;
         evt_ff     <= 1'b0;
      end else if (clkEn) begin
         settled_ff <= settledNow;
         level_ff   <= settledNow && cmpSync_ff;
         evt_ff     <= settledNow && settled_ff && (cmpSync_ff != cmpPrev_ff);
      end
   end

   assign bod.belowSync = cmpSync_ff;
   assign bod.level     = level_ff;
   assign bod.crossEvt  = evt_ff;
endmodule

// ==== design/rcbo_ctrl.sv ====
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ns
`include "rcbo_map.svh"
module rcbo_ctrl
   import rcbo_pkg::*;
#(
   parameter int ADDR_W = 12
)
(
   input  wire logic              sys_clk,
   input  wire logic              reset,
   input  wire logic              clkEn,
   input  wire logic              powerOnReset,
   input  wire logic              resetBySoftware,
   input  wire logic              resetPinRaw,
   input  wire logic              pcOverflow,
   input  wire logic              onChipDebug,
   input  wire logic              debugEnableOption,
   input  wire logic              brownoutCmpRaw,
   input  wire logic              lowSpeedOscillator,
   input  wire logic [7:0]        bootOptionByteTwo,
   input  wire logic              brownoutIrqEnable,
   input  wire logic              globalIrqEnable,
   output logic                   chipResetReq,
   output logic                   brownoutIrq,
   output logic                   brownoutDetectOn,
   output logic [1:0]             brownoutThreshold,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);
   rcbo_bod_if bodIf ();

   logic              awready_ff;
   logic              awHeld_ff;
   logic [ADDR_W-1:0] awAddr_ff;
   logic              wready_ff;
   logic              wHeld_ff;
   logic [7:0]        wData_ff;
   logic              wStrb0_ff;
   logic              bvalid_ff;
   logic [1:0]        bresp_ff;
   logic              arready_ff;
   logic              rvalid_ff;
   logic [31:0]       rdata_ff;
   logic [1:0]        rresp_ff;
   rcbo_ta_t          taState_ff;
   logic [2:0]        taCnt_ff;
   logic              pinMeta_ff;
   logic              pinSync_ff;
   logic              swFlag_ff;
   logic              pinFlag_ff;
   logic              faultFlag_ff;
   logic              bodOn_ff;
   logic [1:0]        lvlSel_ff;
   logic              evtFlag_ff;
   logic              rstOn_ff;
   logic              rstFlag_ff;
   logic              chipResetReq_ff;
   logic              irq_ff;
   logic              doWrite;
   rcbo_idx_t         wrIdx;
   logic              wrAux;
   logic              wrBod;
   logic              wrTa;
   logic              faultReset;
   logic              bodReset;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic rcbo_idx_t regIdx(input logic [ADDR_W-1:0] addr);
      rcbo_idx_t idx;
      idx = rcbo_idx_t'(addr[ADDR_W-1:2]);
      if (addr[1:0] != 2'h0) begin
         return `RCBO_IDX_NONE;
      end
      if (idx == `RCBO_IDX_AUX || idx == `RCBO_IDX_BOD || idx == `RCBO_IDX_TA) begin
         return idx;
      end
      return `RCBO_IDX_NONE;
   endfunction

   assign doWrite = awHeld_ff && wHeld_ff && !bvalid_ff;
   assign wrIdx   = regIdx(awAddr_ff);
   assign wrAux   = doWrite && wStrb0_ff && (wrIdx == `RCBO_IDX_AUX);
   assign wrTa    = doWrite && wStrb0_ff && (wrIdx == `RCBO_IDX_TA);
   assign wrBod   = doWrite && wStrb0_ff && (wrIdx == `RCBO_IDX_BOD)
                    && (taState_ff == TA_OPEN);

   // ----------------------------------------------------------------
   // Write address and data channels
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         awready_ff <= 1'b0;
         awHeld_ff  <= 1'b0;
         awAddr_ff  <= '0;
      end else if (clkEn) begin
         if (s_axi_awvalid && awready_ff) begin
            awready_ff <= 1'b0;
            awHeld_ff  <= 1'b1;
            awAddr_ff  <= s_axi_awaddr;
         end else if (bvalid_ff && s_axi_bready) begin
            awHeld_ff  <= 1'b0;
            awready_ff <= 1'b1;
         end else if (!awHeld_ff) begin
            awready_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         wready_ff <= 1'b0;
         wHeld_ff  <= 1'b0;
         wData_ff  <= 8'h00;
         wStrb0_ff <= 1'b0;
      end else if (clkEn) begin
         if (s_axi_wvalid && wready_ff) begin
            wready_ff <= 1'b0;
            wHeld_ff  <= 1'b1;
            wData_ff  <= s_axi_wdata[7:0];
            wStrb0_ff <= s_axi_wstrb[0];
         end else if (bvalid_ff && s_axi_bready) begin
            wHeld_ff  <= 1'b0;
            wready_ff <= 1'b1;
         end else if (!wHeld_ff) begin
            wready_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= `RCBO_RESP_OKAY;
      end else if (clkEn) begin
         if (doWrite) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= (wrIdx == `RCBO_IDX_NONE) ? `RCBO_RESP_SLVERR : `RCBO_RESP_OKAY;
         end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0000_0000;
         rresp_ff   <= `RCBO_RESP_OKAY;
      end else if (clkEn) begin
         if (s_axi_arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= `RCBO_RESP_OKAY;
            unique case (regIdx(s_axi_araddr))
               `RCBO_IDX_AUX: begin
                  rdata_ff[`RCBO_AUX_SW]    <= swFlag_ff;
                  rdata_ff[`RCBO_AUX_PIN]   <= pinFlag_ff;
                  rdata_ff[`RCBO_AUX_FAULT] <= faultFlag_ff;
               end
               `RCBO_IDX_BOD: begin
                  rdata_ff[`RCBO_BOD_ON]                      <= bodOn_ff;
                  rdata_ff[`RCBO_BOD_LVL_HI:`RCBO_BOD_LVL_LO] <= lvlSel_ff;
                  rdata_ff[`RCBO_BOD_EVT]                     <= evtFlag_ff;
                  rdata_ff[`RCBO_BOD_RSTON]                   <= rstOn_ff;
                  rdata_ff[`RCBO_BOD_RSTF]                    <= rstFlag_ff;
                  rdata_ff[`RCBO_BOD_STATE]                   <= bodIf.level;
               end
               `RCBO_IDX_TA: begin
               end
               default: begin
                  rresp_ff <= `RCBO_RESP_SLVERR;
               end
            endcase
         end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff  <= 1'b0;
            arready_ff <= 1'b1;
         end else if (!rvalid_ff) begin
            arready_ff <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Timed-access guard
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         taState_ff <= TA_LOCKED;
         taCnt_ff   <= 3'h0;
      end else if (clkEn) begin
         if (wrTa && wData_ff == `RCBO_TA_KEY1) begin
            taState_ff <= TA_KEY1;
            taCnt_ff   <= `RCBO_TA_WINDOW;
         end else if (wrTa && taState_ff == TA_KEY1 && wData_ff == `RCBO_TA_KEY2) begin
            taState_ff <= TA_OPEN;
            taCnt_ff   <= `RCBO_TA_WINDOW;
         end else if (doWrite || (taState_ff != TA_LOCKED && taCnt_ff == 3'h0)) begin
            taState_ff <= TA_LOCKED;
         end else if (taCnt_ff != 3'h0) begin
            taCnt_ff <= taCnt_ff - 3'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Reset cause flags
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (powerOnReset) begin
         pinMeta_ff <= 1'b0;
         pinSync_ff <= 1'b0;
      end else if (clkEn || reset) begin
         pinMeta_ff <= resetPinRaw;
         pinSync_ff <= pinMeta_ff;
      end
   end

   assign faultReset = pcOverflow && !(onChipDebug && !debugEnableOption);
   assign bodReset   = rstOn_ff && bodIf.level;

   always_ff @(posedge sys_clk) begin
      if (powerOnReset) begin
         swFlag_ff    <= 1'b0;
         pinFlag_ff   <= 1'b0;
         faultFlag_ff <= 1'b0;
      end else if (reset) begin
         swFlag_ff  <= swFlag_ff | resetBySoftware;
         pinFlag_ff <= pinFlag_ff | pinSync_ff;
      end else if (clkEn) begin
         if (wrAux) begin
            swFlag_ff    <= wData_ff[`RCBO_AUX_SW];
            pinFlag_ff   <= wData_ff[`RCBO_AUX_PIN];
            faultFlag_ff <= wData_ff[`RCBO_AUX_FAULT] | pcOverflow;
         end else if (pcOverflow) begin
            faultFlag_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset || powerOnReset) begin
         chipResetReq_ff <= 1'b0;
      end else if (clkEn && (faultReset || bodReset)) begin
         chipResetReq_ff <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Brown-out control
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset || powerOnReset) begin
         bodOn_ff  <= bootOptionByteTwo[`RCBO_BOD_ON];
         lvlSel_ff <= bootOptionByteTwo[`RCBO_BOD_LVL_HI:`RCBO_BOD_LVL_LO];
         rstOn_ff  <= bootOptionByteTwo[`RCBO_BOD_RSTON];
      end else if (clkEn && wrBod) begin
         bodOn_ff  <= wData_ff[`RCBO_BOD_ON];
         lvlSel_ff <= wData_ff[`RCBO_BOD_LVL_HI:`RCBO_BOD_LVL_LO];
         rstOn_ff  <= wData_ff[`RCBO_BOD_RSTON];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset || powerOnReset) begin
         evtFlag_ff <= bootOptionByteTwo[`RCBO_BOD_ON] && bodIf.belowSync;
      end else if (clkEn) begin
         if (wrBod) begin
            evtFlag_ff <= wData_ff[`RCBO_BOD_EVT] | bodIf.crossEvt;
         end else if (bodIf.crossEvt) begin
            evtFlag_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (powerOnReset) begin
         rstFlag_ff <= 1'b0;
      end else if (!reset && clkEn) begin
         if (wrBod) begin
            rstFlag_ff <= wData_ff[`RCBO_BOD_RSTF] | bodReset;
         end else if (bodReset) begin
            rstFlag_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset || powerOnReset) begin
         irq_ff <= 1'b0;
      end else if (clkEn) begin
         irq_ff <= evtFlag_ff && brownoutIrqEnable && globalIrqEnable;
      end
   end

   // ----------------------------------------------------------------
   // Comparator conditioning
   // ----------------------------------------------------------------
   assign bodIf.detectOn = bodOn_ff;

   rcbo_bod_sense u_sense (
      .sys_clk (sys_clk),
      .reset   (reset),
      .clkEn   (clkEn),
      .cmpRaw  (brownoutCmpRaw),
      .lircRaw (lowSpeedOscillator),
      .bod     (bodIf.sense)
   );

   assign chipResetReq      = chipResetReq_ff;
   assign brownoutIrq       = irq_ff;
   assign brownoutDetectOn  = bodOn_ff;
   assign brownoutThreshold = lvlSel_ff;
   assign s_axi_awready     = awready_ff;
   assign s_axi_wready      = wready_ff;
   assign s_axi_bvalid      = bvalid_ff;
   assign s_axi_bresp       = bresp_ff;
   assign s_axi_arready     = arready_ff;
   assign s_axi_rvalid      = rvalid_ff;
   assign s_axi_rdata       = rdata_ff;
   assign s_axi_rresp       = rresp_ff;
endmodule

// ==== dv/rcbo_ctrl_chk.sv ====
`timescale 1ns/1ns
module rcbo_ctrl_chk
   import rcbo_pkg::*;
(
   input wire logic       sys_clk,
   input wire logic       reset,
   input wire logic       powerOnReset,
   input wire logic       clkEn,
   input wire logic       pcOverflow,
   input wire logic       onChipDebug,
   input wire logic       debugEnableOption,
   input wire logic       brownoutIrqEnable,
   input wire logic       globalIrqEnable,
   input wire logic       chipResetReq,
   input wire logic       brownoutIrq,
   input wire logic       brownoutDetectOn,
   input wire logic [1:0] brownoutThreshold,
   input wire logic       s_axi_awvalid,
   input wire logic       s_axi_awready,
   input wire logic       s_axi_wvalid,
   input wire logic       s_axi_wready,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid
);
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking dc @(posedge sys_clk);
   endclocking
   default disable iff (reset || powerOnReset);

   irq_cause_a:
   assert property (brownoutIrq && $past(clkEn) |-> $past(brownoutIrqEnable && globalIrqEnable))
      else $error("interrupt without both enables");
   fault_req_a:
   assert property (pcOverflow && clkEn && !(onChipDebug && !debugEnableOption) |=> chipResetReq)
      else $error("fault did not request reset");
   debug_mask_a:
   assert property (pcOverflow && onChipDebug && !debugEnableOption && !chipResetReq
                    && !brownoutDetectOn |=> !chipResetReq)
      else $error("fault reset not suppressed in debug");
   req_hold_a:
   assert property (chipResetReq |=> chipResetReq)
      else $error("reset request dropped before reset");
   wr_resp_a:
   assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clkEn
                    |=> ##1 s_axi_bvalid)
      else $error("write answer late");
   ready_back_a:
   assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##[0:1] (s_axi_awready && s_axi_wready))
      else $error("write channel not reopened");
   rd_lat_a:
   assert property (s_axi_arvalid && s_axi_arready && clkEn |=> s_axi_rvalid)
      else $error("read answer late");
   rd_busy_a:
   assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   thr_guard_a:
   assert property ($changed(brownoutThreshold) |-> $past(s_axi_wvalid && s_axi_wready)
                    || $past(s_axi_wvalid && s_axi_wready, 2))
      else $error("level changed without a write");

   cover property (chipResetReq && !$past(chipResetReq));
   cover property (brownoutIrq);
   cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

bind rcbo_ctrl rcbo_ctrl_chk i_rcbo_ctrl_chk (
   .sys_clk, .reset, .powerOnReset, .clkEn, .pcOverflow, .onChipDebug, .debugEnableOption,
   .brownoutIrqEnable, .globalIrqEnable, .chipResetReq, .brownoutIrq, .brownoutDetectOn,
   .brownoutThreshold, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid
);

// ==== dv/rcbo_ctrl_tb.sv ====
`timescale 1ns/1ns
`include "rcbo_map.svh"
module rcbo_ctrl_tb
   import rcbo_pkg::*;
;
   localparam logic [11:0] AUX = {`RCBO_IDX_AUX, 2'b00};
   localparam logic [11:0] BOD = {`RCBO_IDX_BOD, 2'b00};
   localparam logic [11:0] TAR = {`RCBO_IDX_TA, 2'b00};
   localparam logic [1:0]  OK  = `RCBO_RESP_OKAY;
   localparam logic [1:0]  ERR = `RCBO_RESP_SLVERR;
   logic        sys_clk, reset, clkEn, powerOnReset, resetBySoftware, resetPinRaw;
   logic        pcOverflow, onChipDebug, debugEnableOption, brownoutCmpRaw;
   logic        lowSpeedOscillator, brownoutIrqEnable, globalIrqEnable;
   logic        chipResetReq, brownoutIrq, brownoutDetectOn;
   logic [1:0]  brownoutThreshold, s_axi_bresp, s_axi_rresp, rsp;
   logic [7:0]  bootOptionByteTwo;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [30:0] rows [14];
   int          err_count = 0;
   int          n_tests = 0;

   rcbo_ctrl #(.ADDR_W(12)) i_rcbo_ctrl (
      .sys_clk, .reset, .clkEn, .powerOnReset, .resetBySoftware, .resetPinRaw, .pcOverflow,
      .onChipDebug, .debugEnableOption, .brownoutCmpRaw, .lowSpeedOscillator,
      .bootOptionByteTwo, .brownoutIrqEnable, .globalIrqEnable, .chipResetReq, .brownoutIrq,
      .brownoutDetectOn, .brownoutThreshold, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
   );

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      lowSpeedOscillator = 1'b0;
      forever #410 lowSpeedOscillator = ~lowSpeedOscillator;
   end
   initial begin
      repeat (4000) @(posedge sys_clk);
      err_count++;
      report_and_stop();
   end

   // ----------------------------------------------------------------
   // Bus and compare tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      fork
         begin
            do @(posedge sys_clk); while (!s_axi_awready);
            s_axi_awvalid <= 1'b0;
         end
         begin
            do @(posedge sys_clk); while (!s_axi_wready);
            s_axi_wvalid <= 1'b0;
         end
      join
      do @(posedge sys_clk); while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] r = OK);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      do @(posedge sys_clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge sys_clk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, {24'h0, e});
      chk(s_axi_rresp, r);
      @(posedge sys_clk);
   endtask
   task automatic ul(input logic [7:0] d);
      wr(TAR, `RCBO_TA_KEY1);
      wr(TAR, `RCBO_TA_KEY2);
      wr(BOD, d);
   endtask
   task automatic rst(input logic sw, input logic pin, input logic por);
      {reset, powerOnReset, resetBySoftware, resetPinRaw} <= {1'b1, por, sw, pin};
      repeat (10) @(posedge sys_clk);
      {reset, powerOnReset, resetBySoftware, resetPinRaw} <= 4'h0;
      repeat (2) @(posedge sys_clk);
   endtask
   task automatic kick();
      pcOverflow <= 1'b1;
      @(posedge sys_clk);
      pcOverflow <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      {reset, powerOnReset, clkEn, brownoutIrqEnable, globalIrqEnable} = '1;
      {resetBySoftware, resetPinRaw, pcOverflow, onChipDebug, debugEnableOption} = '0;
      {brownoutCmpRaw, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      bootOptionByteTwo = 8'h94;
      rows = '{{1'b1, AUX, 8'hff, 8'h00, OK}, {1'b0, AUX, 8'h00, 8'he0, OK},
               {1'b1, AUX, 8'h00, 8'h00, OK}, {1'b0, AUX, 8'h00, 8'h00, OK},
               {1'b1, BOD, 8'h00, 8'h00, OK}, {1'b0, BOD, 8'h00, 8'h94, OK},
               {1'b1, TAR, 8'haa, 8'h00, OK}, {1'b1, TAR, 8'h55, 8'h00, OK},
               {1'b1, BOD, 8'h24, 8'h00, OK}, {1'b0, BOD, 8'h00, 8'h24, OK},
               {1'b0, 12'hff0, 8'h00, 8'h00, ERR}, {1'b1, 12'hff0, 8'h00, 8'h00, ERR},
               {1'b0, 12'h289, 8'h00, 8'h00, ERR}, {1'b0, TAR, 8'h00, 8'h00, OK}};
      @(posedge sys_clk);
      rst(1'b0, 1'b0, 1'b1);
      chk(chipResetReq, 1'b0);
      chk(brownoutDetectOn, 1'b1);
      chk(brownoutThreshold, 2'b01);
      $display("reset test done");
      foreach (rows[i]) begin
         if (rows[i][30]) begin
            wr(rows[i][29:18], rows[i][17:10]);
            chk(rsp, rows[i][1:0]);
         end else begin
            rd(rows[i][29:18], rows[i][9:2], rows[i][1:0]);
         end
      end
      for (int i = 0; i < 4; i++) begin
         ul({2'b00, i[1:0], 4'h0});
         chk(brownoutThreshold, i[1:0]);
         chk(brownoutDetectOn, 1'b0);
      end
      $display("register test done");
      bootOptionByteTwo <= 8'h14;
      rst(1'b0, 1'b0, 1'b0);
      chk(brownoutDetectOn, 1'b0);
      kick();
      chk(chipResetReq, 1'b1);
      rst(1'b0, 1'b0, 1'b0);
      rd(AUX, 8'h20);
      wr(AUX, 8'h00);
      onChipDebug <= 1'b1;
      kick();
      chk(chipResetReq, 1'b0);
      rd(AUX, 8'h20);
      onChipDebug <= 1'b0;
      wr(AUX, 8'h00);
      rst(1'b1, 1'b0, 1'b0);
      rd(AUX, 8'h80);
      wr(AUX, 8'h00);
      rst(1'b0, 1'b1, 1'b0);
      rd(AUX, 8'h40);
      $display("cause test done");
      brownoutCmpRaw <= 1'b1;
      ul(8'h80);
      rd(BOD, 8'h80);
      brownoutCmpRaw <= 1'b0;
      repeat (80) @(posedge sys_clk);
      rd(BOD, 8'h80);
      {brownoutCmpRaw, globalIrqEnable} <= 2'b10;
      repeat (8) @(posedge sys_clk);
      chk(brownoutIrq, 1'b0);
      chk(chipResetReq, 1'b0);
      {globalIrqEnable, brownoutIrqEnable} <= 2'b10;
      repeat (3) @(posedge sys_clk);
      chk(brownoutIrq, 1'b0);
      brownoutIrqEnable <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk(brownoutIrq, 1'b1);
      rd(BOD, 8'h89);
      brownoutCmpRaw <= 1'b0;
      repeat (8) @(posedge sys_clk);
      rd(BOD, 8'h88);
      ul(8'h80);
      rd(BOD, 8'h80);
      chk(brownoutIrq, 1'b0);
      bootOptionByteTwo <= 8'h94;
      rst(1'b0, 1'b0, 1'b0);
      repeat (80) @(posedge sys_clk);
      brownoutCmpRaw <= 1'b1;
      repeat (8) @(posedge sys_clk);
      chk(chipResetReq, 1'b1);
      rd(BOD, 8'h9f);
      brownoutCmpRaw <= 1'b0;
      rst(1'b0, 1'b0, 1'b0);
      $display("brown-out test done");
      report_and_stop();
   end
endmodule
